// File: verilog/serial_out_cfg_map.vh
`ifndef SERIAL_OUT_CFG_MAP_VH
`define SERIAL_OUT_CFG_MAP_VH
// =============================================
// register offsets
`define ADDR_DEV_INDEX        13'h0005
`define ADDR_CLK_DIVIDER      13'h000B
`define ADDR_OUT_DRV_ADJ      13'h0015
`define ADDR_SAMPLE_CLK_PHASE 13'h0016
`define ADDR_SERIAL_CTRL      13'h0021
`define ADDR_TRANSFER         13'h00FF
`define ADDR_RES_RATE_DOWN    13'h0100
`define ADDR_PULL_CTRL        13'h0101
`define ADDR_CM_GEN_CTRL      13'h0102
// =============================================
// reset values
`define RST_DEV_INDEX         8'h03
`define RST_CLK_DIVIDER       8'h00
`define RST_OUT_DRV_ADJ       8'h00
`define RST_SAMPLE_CLK_PHASE  8'h03
`define RST_SERIAL_CTRL       8'h32
`define RST_RES_RATE_DOWN     8'h00
`define RST_PULL_CTRL         8'h00
`define RST_CM_GEN_CTRL       8'h00
`define RST_DCO_PHASE         4'h3
`define RST_DCO_DEG           10'h0B4
`define RST_DCO_MULT_X2       4'h6
// =============================================
// field positions
`define FLD_TERM_HI           5
`define FLD_TERM_LO           4
`define FLD_DRIVE_2X          0
`define FLD_IN_PHASE_HI       6
`define FLD_IN_PHASE_LO       4
`define FLD_DCO_PHASE_HI      3
`define FLD_DCO_PHASE_LO      0
`define FLD_DIV_HI            2
`define FLD_DIV_LO            0
`define FLD_MODE_HI           6
`define FLD_MODE_LO           4
`define FLD_LOW_ENC           3
`define FLD_FRAME_2X          2
`define FLD_WIDTH_HI          1
`define FLD_WIDTH_LO          0
`define FLD_RATE_HI           2
`define FLD_RATE_LO           0
`define FLD_RES_HI            5
`define FLD_RES_LO            4
`define FLD_OVR_EN            6
`define FLD_XFER              0
`define FLD_PULL_DIS          0
`define FLD_CM_PD             3
`define FLD_CH_HI             1
`define FLD_CH_LO             0
// =============================================
// field codes
`define WIDTH_12              2'h2
`define WIDTH_10              2'h3
`define MODE_DDR_1LANE        3'h4
`define MODE_SDR_BIT          3'h0
`define MODE_SDR_BYTE         3'h1
`define MODE_DDR_BIT          3'h2
`define MODE_DDR_BYTE         3'h3
`define DCO_PHASE_MAX         4'hB
`define DCO_STEP_DEG          10'h03C
`endif

// File: verilog/sample_phase_delay.v
`timescale 1ns/100ps
// =============================================
// sampling instant delay by whole input clocks
module sample_phase_delay #(
  parameter DEPTH = 8                      // max delay plus one
) (
  input  wire       clk_i,                 // converter clock
  input  wire       rst_n_i,               // sync reset, active low
  input  wire       strobe_i,              // undelayed sample strobe
  input  wire       div_active_i,          // clock divider in use
  input  wire [2:0] phase_i,               // delay in input clocks
  output reg        strobe_o               // delayed sample strobe
);
  reg [DEPTH-1:0] tap_r;
  // shift line, tap 0 is the strobe delayed one clock
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tap_r <= {DEPTH{1'b0}};
    end else begin
      tap_r <= {tap_r[DEPTH-2:0], strobe_i};
    end
  end
  // pick delay only while dividing
  always @* begin
    if (!div_active_i || phase_i == 3'h0) begin
      strobe_o = strobe_i;
    end else begin
      strobe_o = tap_r[phase_i - 3'h1];
    end
  end
endmodule

// File: verilog/serial_out_cfg.v
`timescale 1ns/100ps
`include "serial_out_cfg_map.vh"
// =============================================
// serial output stage configuration
//
// Contract
// - two-bit termination field selects internal output termination resistor
// - drive bit sets 2x on frame/data clock outputs selected by index
// - termination selected overrides the 2x clock drive
// - with divider active, sampling delayed 0 to 7 input clocks by field
// - data clock shifted 60 degrees per code, codes 0 to 11, reset 3
// - serialization register resets to 12-bit 1x DDR two-lane bytewise
// - lane mode and rate from register; clock multiplier follows mode
// - 12 or 10 bit words, 1x or 2x frame, 10-bit multipliers 2.5x/5x
// - override register takes effect only after transfer bit written
// - rate field limits maximum rate capability, not conversion rate
// - set bit disconnects serial data pin pull-down
// - set bit powers down common mode generator
// - all other registers take effect immediately on write
// - channel select picks which channels get per-channel settings
module serial_out_cfg (
  input  wire        clk_i,               // converter clock, 10 MHz
  input  wire        rst_n_i,             // sync reset, active low
  input  wire        wr_i,                // register write strobe
  input  wire        rd_i,                // register read strobe
  input  wire [12:0] addr_i,              // register address
  input  wire [7:0]  wdata_i,             // write data
  output reg  [7:0]  rdata_o,             // read data
  input  wire        sample_strobe_i,     // undelayed sample strobe
  output wire        sample_strobe_o,     // sampling instant
  output reg  [1:0]  termination_o,       // termination select
  output reg  [1:0]  clk_drive_2x_o,      // 2x drive per clock output
  output reg  [3:0]  dco_phase_o,         // data clock phase code
  output reg  [9:0]  dco_phase_deg_o,     // data clock shift, degrees
  output reg         dco_phase_bad_o,     // reserved code set
  output reg  [1:0]  serial_word_width_o, // word width code
  output reg         frame_2x_o,          // 2x frame mode
  output reg  [2:0]  lane_mode_o,         // serial data lane mode
  output reg         low_encode_o,        // low encode mode
  output reg  [3:0]  dco_mult_x2_o,       // data clock multiple, times two
  output reg  [1:0]  res_active_o,        // committed resolution code
  output reg  [2:0]  rate_cap_o,          // committed rate capability
  output reg         ovr_en_o,            // committed override enable
  output reg         pull_down_dis_o,     // serial pin pull-down off
  output reg         cm_gen_pd_o          // common mode generator off
);
  // register storage and commit state
  reg [7:0] dev_index_r;
  reg [7:0] clk_div_r;
  reg [7:0] out_drv_adj_r;
  reg [7:0] phase_r;
  reg [7:0] serial_ctrl_r;
  reg [7:0] res_rate_r;
  reg [7:0] res_rate_act_r;
  reg [7:0] pull_ctrl_r;
  reg [7:0] cm_ctrl_r;
  reg [1:0] drive_ch_r;
  reg       xfer_r;
  wire [1:0] ch_sel;
  wire [2:0] in_phase;

  // channel select and input phase fields
  assign ch_sel   = dev_index_r[`FLD_CH_HI:`FLD_CH_LO];
  assign in_phase = phase_r[`FLD_IN_PHASE_HI:`FLD_IN_PHASE_LO];

  // =============================================
  // register writes, immediate except override
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dev_index_r   <= `RST_DEV_INDEX;
      clk_div_r     <= `RST_CLK_DIVIDER;
      out_drv_adj_r <= `RST_OUT_DRV_ADJ;
      phase_r       <= `RST_SAMPLE_CLK_PHASE;
      serial_ctrl_r <= `RST_SERIAL_CTRL;
      res_rate_r    <= `RST_RES_RATE_DOWN;
      pull_ctrl_r   <= `RST_PULL_CTRL;
      cm_ctrl_r     <= `RST_CM_GEN_CTRL;
      drive_ch_r    <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `ADDR_DEV_INDEX:        dev_index_r   <= wdata_i;
        `ADDR_CLK_DIVIDER:      clk_div_r     <= wdata_i;
        `ADDR_OUT_DRV_ADJ: begin
          out_drv_adj_r <= wdata_i;
          // drive bit lands only on selected clock outputs
          if (ch_sel[0]) drive_ch_r[0] <= wdata_i[`FLD_DRIVE_2X];
          if (ch_sel[1]) drive_ch_r[1] <= wdata_i[`FLD_DRIVE_2X];
        end
        `ADDR_SAMPLE_CLK_PHASE: phase_r       <= wdata_i;
        `ADDR_SERIAL_CTRL:      serial_ctrl_r <= wdata_i;
        `ADDR_RES_RATE_DOWN:    res_rate_r    <= wdata_i; // shadow only
        `ADDR_PULL_CTRL:        pull_ctrl_r   <= wdata_i;
        `ADDR_CM_GEN_CTRL:      cm_ctrl_r     <= wdata_i;
        default: ;
      endcase
    end
  end

  // =============================================
  // transfer strobe commits override shadow
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_rate_act_r <= `RST_RES_RATE_DOWN;
      xfer_r         <= 1'b0;
    end else begin
      // transfer write registered, commit one edge later
      xfer_r <= wr_i && addr_i == `ADDR_TRANSFER && wdata_i[`FLD_XFER];
      if (xfer_r) begin
        res_rate_act_r <= res_rate_r;
      end
    end
  end

  // =============================================
  // read mux, transfer bit self-clears
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_DEV_INDEX:        rdata_o <= dev_index_r;
        `ADDR_CLK_DIVIDER:      rdata_o <= clk_div_r;
        `ADDR_OUT_DRV_ADJ:      rdata_o <= out_drv_adj_r & 8'h31;
        `ADDR_SAMPLE_CLK_PHASE: rdata_o <= phase_r & 8'h7F;
        `ADDR_SERIAL_CTRL:      rdata_o <= serial_ctrl_r;
        `ADDR_RES_RATE_DOWN:    rdata_o <= res_rate_r & 8'h77;
        `ADDR_PULL_CTRL:        rdata_o <= pull_ctrl_r & 8'h01;
        `ADDR_CM_GEN_CTRL:      rdata_o <= cm_ctrl_r & 8'h08;
        default:                rdata_o <= 8'h00;
      endcase
    end
  end

  // =============================================
  // driver and phase outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      termination_o   <= 2'h0;
      clk_drive_2x_o  <= 2'h0;
      dco_phase_o     <= `RST_DCO_PHASE;
      dco_phase_deg_o <= `RST_DCO_DEG;
      dco_phase_bad_o <= 1'b0;
    end else begin
      termination_o <= out_drv_adj_r[`FLD_TERM_HI:`FLD_TERM_LO];
      // termination wins over doubled clock drive
      if (out_drv_adj_r[`FLD_TERM_HI:`FLD_TERM_LO] != 2'h0) begin
        clk_drive_2x_o <= 2'h0;
      end else begin
        clk_drive_2x_o <= drive_ch_r;
      end
      // data clock phase code, degrees and reserved flag
      dco_phase_o     <= phase_r[`FLD_DCO_PHASE_HI:`FLD_DCO_PHASE_LO];
      dco_phase_deg_o <= `DCO_STEP_DEG *
                         {6'h00, phase_r[`FLD_DCO_PHASE_HI:`FLD_DCO_PHASE_LO]};
      dco_phase_bad_o <= phase_r[`FLD_DCO_PHASE_HI:`FLD_DCO_PHASE_LO] >
                         `DCO_PHASE_MAX;
    end
  end

  // =============================================
  // serialization mode and clock multiplier
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_word_width_o <= `WIDTH_12;
      frame_2x_o          <= 1'b0;
      lane_mode_o         <= `MODE_DDR_BYTE;
      low_encode_o        <= 1'b0;
      dco_mult_x2_o       <= `RST_DCO_MULT_X2;
    end else begin
      // fields passed straight from the register
      serial_word_width_o <= serial_ctrl_r[`FLD_WIDTH_HI:`FLD_WIDTH_LO];
      frame_2x_o          <= serial_ctrl_r[`FLD_FRAME_2X];
      lane_mode_o         <= serial_ctrl_r[`FLD_MODE_HI:`FLD_MODE_LO];
      low_encode_o        <= serial_ctrl_r[`FLD_LOW_ENC];
      // multiplier kept doubled so 2.5x stays integral
      case ({serial_ctrl_r[`FLD_WIDTH_LO], serial_ctrl_r[`FLD_MODE_HI:`FLD_MODE_LO]})
        4'h0, 4'h1:        dco_mult_x2_o <= 4'hC;
        4'h2, 4'h3:        dco_mult_x2_o <= 4'h6;
        4'h4:              dco_mult_x2_o <= 4'hC;
        4'h8, 4'h9:        dco_mult_x2_o <= 4'hA;
        4'hA, 4'hB:        dco_mult_x2_o <= 4'h5;
        4'hC:              dco_mult_x2_o <= 4'hA;
        default:           dco_mult_x2_o <= 4'h0;
      endcase
    end
  end

  // =============================================
  // committed override and user io controls
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_active_o    <= 2'h0;
      rate_cap_o      <= 3'h0;
      ovr_en_o        <= 1'b0;
      pull_down_dis_o <= 1'b0;
      cm_gen_pd_o     <= 1'b0;
    end else begin
      res_active_o    <= res_rate_act_r[`FLD_RES_HI:`FLD_RES_LO];
      rate_cap_o      <= res_rate_act_r[`FLD_RATE_HI:`FLD_RATE_LO];
      ovr_en_o        <= res_rate_act_r[`FLD_OVR_EN];
      pull_down_dis_o <= pull_ctrl_r[`FLD_PULL_DIS];
      cm_gen_pd_o     <= cm_ctrl_r[`FLD_CM_PD];
    end
  end

  // =============================================
  // sampling instant delay while divider active
  sample_phase_delay #(
    .DEPTH (8)
  ) u_delay (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .strobe_i     (sample_strobe_i),
    .div_active_i (clk_div_r[`FLD_DIV_HI:`FLD_DIV_LO] != 3'h0),
    .phase_i      (in_phase),
    .strobe_o     (sample_strobe_o)
  );
endmodule

// File: testbench/serial_out_cfg_assertions.sv
`timescale 1ns/100ps
// ==========
// port checks
module serial_out_cfg_assertions (
  input logic        clk_i,               // clock
  input logic        rst_n_i,             // reset
  input logic        wr_i,                // write
  input logic [12:0] addr_i,              // address
  input logic [7:0]  wdata_i,             // data
  input logic [1:0]  termination_o,       // term
  input logic [1:0]  clk_drive_2x_o,      // drive
  input logic [3:0]  dco_phase_o,         // phase
  input logic [9:0]  dco_phase_deg_o,     // degrees
  input logic        dco_phase_bad_o,     // reserved
  input logic [1:0]  serial_word_width_o, // width
  input logic [2:0]  lane_mode_o,         // mode
  input logic [3:0]  dco_mult_x2_o,       // mult
  input logic [1:0]  res_active_o,        // res
  input logic [2:0]  rate_cap_o,          // rate
  input logic        ovr_en_o,            // ovr
  input logic        pull_down_dis_o,     // pull
  input logic        cm_gen_pd_o          // cm
);
  logic       xfer_wr;
  logic [7:0] wd_d1, wd_d2;
  // transfer decode and delayed write data
  assign xfer_wr = wr_i && (addr_i == 13'h00FF) && wdata_i[0];
  always @(posedge clk_i) begin
    wd_d1 <= wdata_i;
    wd_d2 <= wd_d1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // expected clock multiple, times two
  function automatic logic [3:0] mx2(input logic [1:0] w, input logic [2:0] m);
    if (m == 3'h4) return (w == 2'h3) ? 4'hA : 4'hC;
    return (w == 2'h3) ? (m[1] ? 4'h5 : 4'hA) : (m[1] ? 4'h6 : 4'hC);
  endfunction
  a_term_write: assert property (
    wr_i && addr_i == 13'h0015 |-> ##2 termination_o == wd_d2[5:4])
    else $error("termination not taken");
  a_term_over_drive: assert property (
    termination_o != 2'h0 |-> clk_drive_2x_o == 2'h0)
    else $error("drive doubled with termination");
  a_mode_write: assert property (
    wr_i && addr_i == 13'h0021 |-> ##2 (lane_mode_o == wd_d2[6:4]
    && serial_word_width_o == wd_d2[1:0]))
    else $error("mode not taken");
  a_mult_match: assert property (
    serial_word_width_o[1] && lane_mode_o <= 3'h4
    |-> dco_mult_x2_o == mx2(serial_word_width_o, lane_mode_o))
    else $error("clock multiple wrong");
  a_deg_match: assert property (dco_phase_deg_o == dco_phase_o * 10'h03C)
    else $error("phase degrees wrong");
  a_bad_flag: assert property (dco_phase_bad_o == (dco_phase_o > 4'hB))
    else $error("reserved flag wrong");
  a_ovr_commit_only: assert property (
    $changed({res_active_o, rate_cap_o, ovr_en_o})
    |-> $past(xfer_wr, 2) || $past(xfer_wr, 3))
    else $error("override changed without transfer");
  a_pull_write: assert property (
    wr_i && addr_i == 13'h0101 |=> ##1 pull_down_dis_o == wd_d2[0])
    else $error("pull-down control not taken");
  a_cm_rise: assert property (
    $rose(cm_gen_pd_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == 13'h0102)
    else $error("generator off without write");
endmodule
bind serial_out_cfg serial_out_cfg_assertions serial_out_cfg_assertions_i (
  .clk_i               (clk_i),
  .rst_n_i             (rst_n_i),
  .wr_i                (wr_i),
  .addr_i              (addr_i),
  .wdata_i             (wdata_i),
  .termination_o       (termination_o),
  .clk_drive_2x_o      (clk_drive_2x_o),
  .dco_phase_o         (dco_phase_o),
  .dco_phase_deg_o     (dco_phase_deg_o),
  .dco_phase_bad_o     (dco_phase_bad_o),
  .serial_word_width_o (serial_word_width_o),
  .lane_mode_o         (lane_mode_o),
  .dco_mult_x2_o       (dco_mult_x2_o),
  .res_active_o        (res_active_o),
  .rate_cap_o          (rate_cap_o),
  .ovr_en_o            (ovr_en_o),
  .pull_down_dis_o     (pull_down_dis_o),
  .cm_gen_pd_o         (cm_gen_pd_o)
);

// File: testbench/host_port_model.sv
`timescale 1ns/100ps
// ==========
// host on the register port
module host_port_model (
  input  wire        clk_i,   // clock
  output reg         wr_o,    // write
  output reg         rd_o,    // read
  output reg  [12:0] addr_o,  // address
  output reg  [7:0]  wdata_o, // data
  input  wire [7:0]  rdata_i  // read data
);
  // idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 13'h0000;
    wdata_o = 8'h00;
  end
  // one-edge write strobe
  task write_reg(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // one-edge read strobe, data held until next read
  task read_reg(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic       clk_i, rst_n_i, wr_i, rd_i, sample_strobe_i, sample_strobe_o, dco_phase_bad_o;
  logic       frame_2x_o, low_encode_o, ovr_en_o, pull_down_dis_o, cm_gen_pd_o;
  logic [12:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rv;
  logic [1:0] termination_o, clk_drive_2x_o, serial_word_width_o, res_active_o;
  logic [2:0] lane_mode_o, rate_cap_o;
  logic [3:0] dco_phase_o, dco_mult_x2_o;
  logic [9:0] dco_phase_deg_o;
  int         mismatches, cmp_count, i;
  serial_out_cfg serial_out_cfg_i (
    .clk_i               (clk_i),
    .rst_n_i             (rst_n_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .rdata_o             (rdata_o),
    .sample_strobe_i     (sample_strobe_i),
    .sample_strobe_o     (sample_strobe_o),
    .termination_o       (termination_o),
    .clk_drive_2x_o      (clk_drive_2x_o),
    .dco_phase_o         (dco_phase_o),
    .dco_phase_deg_o     (dco_phase_deg_o),
    .dco_phase_bad_o     (dco_phase_bad_o),
    .serial_word_width_o (serial_word_width_o),
    .frame_2x_o          (frame_2x_o),
    .lane_mode_o         (lane_mode_o),
    .low_encode_o        (low_encode_o),
    .dco_mult_x2_o       (dco_mult_x2_o),
    .res_active_o        (res_active_o),
    .rate_cap_o          (rate_cap_o),
    .ovr_en_o            (ovr_en_o),
    .pull_down_dis_o     (pull_down_dis_o),
    .cm_gen_pd_o         (cm_gen_pd_o)
  );
  host_port_model host_port_model_i (.clk_i(clk_i), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .rdata_i(rdata_o));
  // ==========
  // helpers
  task cmp(input string n, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task w(input logic [12:0] a, input logic [7:0] d);
    host_port_model_i.write_reg(a, d);
  endtask
  task r(input logic [12:0] a, input logic [7:0] e);
    host_port_model_i.read_reg(a, rv);
    cmp("rdata", {2'h0, e}, {2'h0, rv});
  endtask
  task wc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task give_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // scenarios
  task t_modes;
    static logic [7:0] c [0:10] = '{8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h42,
                                    8'h33, 8'h13, 8'h03, 8'h43, 8'h4A};
    static logic [3:0] m [0:10] = '{4'h6, 4'h6, 4'hC, 4'hC, 4'h6, 4'hC,
                                    4'h5, 4'hA, 4'hA, 4'hA, 4'hC};
    for (i = 0; i < 11; i++) begin
      w(13'h0021, c[i]);
      wc(2);
      cmp("mode", {7'h00, c[i][6:4]}, {7'h00, lane_mode_o});
      cmp("width", {8'h00, c[i][1:0]}, {8'h00, serial_word_width_o});
      cmp("frame", {9'h000, c[i][2]}, {9'h000, frame_2x_o});
      cmp("low enc", {9'h000, c[i][3]}, {9'h000, low_encode_o});
      cmp("mult", {6'h00, m[i]}, {6'h00, dco_mult_x2_o});
    end
    r(13'h0021, 8'h4A);
  endtask
  task t_phase;
    for (i = 0; i < 13; i++) begin
      w(13'h0016, i[7:0]);
      wc(2);
      cmp("degrees", i[9:0] * 10'h03C, dco_phase_deg_o);
      cmp("reserved", {9'h000, i > 11}, {9'h000, dco_phase_bad_o});
    end
  endtask
  task t_drive;
    w(13'h0005, 8'h01);
    w(13'h0015, 8'h01);
    wc(2);
    cmp("drive", 10'h001, {8'h00, clk_drive_2x_o});
    w(13'h0005, 8'h02);
    w(13'h0015, 8'h00);
    wc(2);
    cmp("drive", 10'h001, {8'h00, clk_drive_2x_o});
    w(13'h0005, 8'h03);
    w(13'h0015, 8'hF1);
    wc(2);
    cmp("term", 10'h003, {8'h00, termination_o});
    cmp("drive", 10'h000, {8'h00, clk_drive_2x_o});
    r(13'h0015, 8'h31);
  endtask
  task strobe(input int e);
    int k, s;
    s = -1;
    sample_strobe_i = 1'b1;
    for (k = 0; k < 10; k++) begin
      #5;
      if (sample_strobe_o === 1'b1 && s < 0) s = k;
      @(posedge clk_i);
      #1;
      sample_strobe_i = 1'b0;
    end
    cmp("delay", e[9:0], s[9:0]);
  endtask
  // delayed sampling only while dividing
  task t_sample;
    w(13'h000B, 8'h07);
    w(13'h0016, 8'h53);
    wc(2);
    strobe(5);
    w(13'h000B, 8'h00);
    wc(2);
    strobe(0);
    w(13'h0016, 8'h03);
  endtask
  task t_other;
    w(13'h0100, 8'h74);
    wc(3);
    cmp("rate early", 10'h000, {7'h00, rate_cap_o});
    w(13'h00FF, 8'h01);
    wc(3);
    cmp("override", 10'h03C, {4'h0, ovr_en_o, res_active_o, rate_cap_o});
    r(13'h00FF, 8'h00);
    w(13'h0101, 8'hFF);
    w(13'h0102, 8'hFF);
    wc(2);
    cmp("pins", 10'h003, {8'h00, pull_down_dis_o, cm_gen_pd_o});
    r(13'h0102, 8'h08);
    w(13'h0101, 8'hFE);
    w(13'h0102, 8'hF7);
    w(13'h0050, 8'hAA);
    wc(2);
    cmp("pins", 10'h000, {8'h00, pull_down_dis_o, cm_gen_pd_o});
    r(13'h0050, 8'h00);
  endtask
  // ==========
  // clock, watchdog, main sequence
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    mismatches++;
    give_verdict;
  end
  initial begin
    rst_n_i = 1'b0;
    sample_strobe_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    cmp("reset", 10'h0DB, {dco_phase_o, lane_mode_o, dco_mult_x2_o[3:1]});
    r(13'h0021, 8'h32);
    r(13'h0016, 8'h03);
    t_modes;
    t_phase;
    t_drive;
    t_sample;
    t_other;
    give_verdict;
  end
endmodule
